//--- rgb_led_pwm_i2c_pkg.sv
// Shared constants and types for the three-channel LED PWM target
package rgb_led_pwm_i2c_pkg;

  // ****************************************************************
  // Clock and PWM timing
  // ****************************************************************
  localparam int CLK_HZ          = 25_000_000;
  localparam int PWM_FREQ_HZ     = 3_000;
  localparam int PWM_STEPS       = 15;
  localparam int PRESCALE_CYCLES = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam logic [9:0] PRESCALE_LAST = 10'(PRESCALE_CYCLES - 1);
  localparam logic [3:0] PHASE_LAST    = 4'(PWM_STEPS - 1);

  // ****************************************************************
  // Link framing
  // ****************************************************************
  localparam logic [6:0] TARGET_ADDR = 7'h55;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] ACK_SLOT    = 4'h8;
  localparam logic [3:0] MASTER_ACK  = 4'h9;
  localparam int         SUB_STEP_BIT = 7;

  // ****************************************************************
  // Sub-address codes and control fields
  // ****************************************************************
  localparam logic [6:0] SUB_DUTY0 = 7'h01;
  localparam logic [6:0] SUB_DUTY1 = 7'h02;
  localparam logic [6:0] SUB_DUTY2 = 7'h03;
  localparam logic [6:0] SUB_CTRL  = 7'h04;
  localparam int         CTRL_ENABLE_BIT = 1;
  localparam int         CTRL_PDN_BIT    = 0;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_ADDR   = 3'b000,
    ST_SUB    = 3'b001,
    ST_DATA   = 3'b010,
    ST_READ   = 3'b011,
    ST_IGNORE = 3'b100
  } eng_state_t;

  typedef struct packed {
    logic [6:0] sub;
    logic [7:0] data;
  } write_req_t;

  typedef struct packed {
    logic [2:0][7:0] duty;
    logic [7:0]      ctrl;
  } settings_t;

endpackage : rgb_led_pwm_i2c_pkg

//--- rgb_led_pwm_i2c_regs.sv
// I2C target register logic and PWM outputs of a three-channel LED driver
//
// Operation
// - Each duty register uses only its low four bits, giving N fifteenths of on time.
// - Control bit 1 enables the outputs, and when low all outputs stay off.
// - Control bit 0 low puts the device into power saving with outputs off.
// - With stepping on, each further data byte goes to the next sub-address.
// - The first read byte holds enable in bit 5, power-down in bit 4, channel 2 duty low.
// - After the master acknowledges, the second read byte holds channel 1 and 0 duty.
// - Sub-address bit 7 high stops stepping and codes 1 to 4 pick the register.
// - The device answers only target address 1010101, with the last bit choosing read.
`timescale 1ns/10ps
module rgb_led_pwm_i2c_regs (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      led_out_0,
  output logic      led_out_1,
  output logic      led_out_2,
  output logic      power_save
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                             sda_s1, sda_s2, sda_s3;
  logic                             scl_s1, scl_s2, scl_s3;
  logic                             start_det, stop_det;
  logic                             start_lvl, frame_on;
  logic                             start_f1, start_f2;
  logic                             wt_s1, wt_s2, wt_s3;
  logic                             wr_event;
  rgb_led_pwm_i2c_pkg::settings_t   settings;
  rgb_led_pwm_i2c_pkg::write_req_t  wr_req;
  logic                             wr_tgl;
  rgb_led_pwm_i2c_pkg::eng_state_t  state;
  logic [3:0]                       cnt;
  logic [7:0]                       rx_shift;
  logic [7:0]                       tx;
  logic [6:0]                       sub;
  logic [6:0]                       next_sub;
  logic                             step_dis;
  logic                             is_read;
  logic                             second;
  logic                             drive;
  logic [7:0]                       first_byte, second_byte;
  logic [9:0]                       prescale;
  logic [3:0]                       phase;
  logic                             pwm_on;
  logic [2:0]                       led;

  // ****************************************************************
  // Pin synchronisers and start/stop detection
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    sda_s1 <= sda_i;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
    scl_s1 <= scl;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
  end

  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // Held until the first SCL rise, so the link side catches it on two edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_lvl <= 1'b0;
    end else if (start_det) begin
      start_lvl <= 1'b1;
    end else if (scl_s2 & ~scl_s3) begin
      start_lvl <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_on <= 1'b0;
    end else if (start_det) begin
      frame_on <= 1'b1;
    end else if (stop_det) begin
      frame_on <= 1'b0;
    end
  end

  // ****************************************************************
  // Link clock domain
  // ****************************************************************
  // Start crosses on the falling then rising edge of the frame itself
  // Reset reaches the link side directly: SCL idles high, so no edge races its release
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      start_f1 <= 1'b0;
    end else begin
      start_f1 <= start_lvl;
    end
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      start_f2 <= 1'b0;
    end else begin
      start_f2 <= start_f1;
    end
  end

  always_ff @(posedge scl) begin
    rx_shift <= {rx_shift[6:0], sda_i};
  end

  // Settings only change after a completed write, so they are stable here
  // first byte
  assign first_byte  = {2'b00,
                        settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_ENABLE_BIT],
                        settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_PDN_BIT],
                        settings.duty[2][3:0]};
  assign second_byte = {settings.duty[1][3:0], settings.duty[0][3:0]};
  assign next_sub    = (sub == rgb_led_pwm_i2c_pkg::SUB_CTRL) ?
                       rgb_led_pwm_i2c_pkg::SUB_DUTY0 : 7'(sub + 7'h01);

  // Toggle must start known, or no write ever reaches the register file
  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      state    <= rgb_led_pwm_i2c_pkg::ST_IGNORE;
      cnt      <= 4'h0;
      drive    <= 1'b0;
      second   <= 1'b0;
      is_read  <= 1'b0;
      step_dis <= 1'b0;
      sub      <= 7'h00;
      tx       <= 8'h00;
      wr_req   <= '0;
      wr_tgl   <= 1'b0;
    end else if (start_f2) begin
      state  <= rgb_led_pwm_i2c_pkg::ST_ADDR;
      cnt    <= 4'h1;
      drive  <= 1'b0;
      second <= 1'b0;
    end else begin
      case (state)
        rgb_led_pwm_i2c_pkg::ST_ADDR,
        rgb_led_pwm_i2c_pkg::ST_SUB,
        rgb_led_pwm_i2c_pkg::ST_DATA: begin
          if (cnt == rgb_led_pwm_i2c_pkg::BIT_LAST) begin
            cnt <= rgb_led_pwm_i2c_pkg::ACK_SLOT;
            if (state == rgb_led_pwm_i2c_pkg::ST_ADDR) begin
              if (rx_shift[7:1] == rgb_led_pwm_i2c_pkg::TARGET_ADDR) begin
                drive   <= 1'b1;
                is_read <= rx_shift[0];
              end else begin
                state <= rgb_led_pwm_i2c_pkg::ST_IGNORE;
              end
            end else if (state == rgb_led_pwm_i2c_pkg::ST_SUB) begin
              sub      <= rx_shift[6:0];
              step_dis <= rx_shift[rgb_led_pwm_i2c_pkg::SUB_STEP_BIT];
              drive    <= 1'b1;
            end else begin
              wr_req <= '{sub: sub, data: rx_shift};
              wr_tgl <= ~wr_tgl;
              drive  <= 1'b1;
            end
          end else if (cnt == rgb_led_pwm_i2c_pkg::ACK_SLOT) begin
            drive <= 1'b0;
            cnt   <= 4'h0;
            if (state == rgb_led_pwm_i2c_pkg::ST_ADDR && is_read) begin
              state <= rgb_led_pwm_i2c_pkg::ST_READ;
              tx    <= first_byte;
              drive <= ~first_byte[7];
              cnt   <= 4'h1;
            end else if (state == rgb_led_pwm_i2c_pkg::ST_ADDR) begin
              state <= rgb_led_pwm_i2c_pkg::ST_SUB;
            end else if (state == rgb_led_pwm_i2c_pkg::ST_SUB) begin
              state <= rgb_led_pwm_i2c_pkg::ST_DATA;
            end else if (step_dis) begin
              state <= rgb_led_pwm_i2c_pkg::ST_SUB;
            end else begin
              sub <= next_sub;
            end
          end else begin
            cnt <= 4'(cnt + 4'h1);
          end
        end
        rgb_led_pwm_i2c_pkg::ST_READ: begin
          if (cnt < rgb_led_pwm_i2c_pkg::ACK_SLOT) begin
            tx    <= {tx[6:0], 1'b0};
            drive <= ~tx[6];
            cnt   <= 4'(cnt + 4'h1);
          end else if (cnt == rgb_led_pwm_i2c_pkg::ACK_SLOT) begin
            drive <= 1'b0;
            cnt   <= rgb_led_pwm_i2c_pkg::MASTER_ACK;
          end else if (!rx_shift[0] && !second) begin
            tx     <= second_byte;
            drive  <= ~second_byte[7];
            second <= 1'b1;
            cnt    <= 4'h1;
          end else begin
            state <= rgb_led_pwm_i2c_pkg::ST_IGNORE;
            drive <= 1'b0;
          end
        end
        rgb_led_pwm_i2c_pkg::ST_IGNORE: begin
          drive <= 1'b0;
        end
        default: begin
          state <= rgb_led_pwm_i2c_pkg::ST_IGNORE;
          drive <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low, and never outside a frame
  assign sda_o  = 1'b0;
  assign sda_oe = drive & frame_on;

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    wt_s1 <= wr_tgl;
    wt_s2 <= wt_s1;
    wt_s3 <= wt_s2;
  end

  assign wr_event = wt_s2 ^ wt_s3;

  // Unmapped sub-addresses are acknowledged but not stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settings.duty <= {3{rgb_led_pwm_i2c_pkg::DUTY_RESET}};
      settings.ctrl <= rgb_led_pwm_i2c_pkg::CTRL_RESET;
    end else if (wr_event) begin
      case (wr_req.sub)
        rgb_led_pwm_i2c_pkg::SUB_DUTY0: settings.duty[0] <= wr_req.data;
        rgb_led_pwm_i2c_pkg::SUB_DUTY1: settings.duty[1] <= wr_req.data;
        rgb_led_pwm_i2c_pkg::SUB_DUTY2: settings.duty[2] <= wr_req.data;
        rgb_led_pwm_i2c_pkg::SUB_CTRL:  settings.ctrl    <= wr_req.data;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // PWM
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prescale <= 10'h000;
      phase    <= 4'h0;
    end else if (prescale == rgb_led_pwm_i2c_pkg::PRESCALE_LAST) begin
      prescale <= 10'h000;
      phase    <= (phase == rgb_led_pwm_i2c_pkg::PHASE_LAST) ? 4'h0 : 4'(phase + 4'h1);
    end else begin
      prescale <= 10'(prescale + 10'h001);
    end
  end

  assign pwm_on = settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_ENABLE_BIT] &
                  settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_PDN_BIT];

  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        led[ch] <= 1'b0;
      end else begin
        led[ch] <= pwm_on & (phase < settings.duty[ch][3:0]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      power_save <= 1'b1;
    end else begin
      power_save <= ~settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_PDN_BIT];
    end
  end

  assign led_out_0 = led[0];
  assign led_out_1 = led[1];
  assign led_out_2 = led[2];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_DUTY_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (settings.duty[0][3:0] == 4'h0) [*2] |-> !led_out_0)
    else $error("Channel 0 on with zero duty");
  AST_DUTY_FULL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pwm_on && settings.duty[1][3:0] == 4'hF) [*2] |-> led_out_1)
    else $error("Channel 1 off with full duty");
  AST_DUTY_PHASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $stable(settings) && pwm_on |=> led_out_2 == ($past(phase) < $past(settings.duty[2][3:0])))
    else $error("Channel 2 does not follow its duty");
  AST_ENABLE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_ENABLE_BIT] |=> led == 3'h0)
    else $error("Output on while disabled");
  AST_PDN_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !settings.ctrl[rgb_led_pwm_i2c_pkg::CTRL_PDN_BIT] |=> power_save && led == 3'h0)
    else $error("Power-down not honoured");
  AST_WRITE_LAND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_event && wr_req.sub == rgb_led_pwm_i2c_pkg::SUB_CTRL |=> settings.ctrl == $past(wr_req.data))
    else $error("Control write not stored");
  AST_AUTO_STEP: assert property (@(negedge scl) disable iff (!rst_n)
    !start_f2 && state == rgb_led_pwm_i2c_pkg::ST_DATA && cnt == rgb_led_pwm_i2c_pkg::ACK_SLOT
      && !step_dis |=> sub == $past(next_sub) && state == rgb_led_pwm_i2c_pkg::ST_DATA)
    else $error("Sub-address did not step");
  AST_STEP_OFF: assert property (@(negedge scl) disable iff (!rst_n)
    !start_f2 && state == rgb_led_pwm_i2c_pkg::ST_DATA && cnt == rgb_led_pwm_i2c_pkg::ACK_SLOT
      && step_dis |=> state == rgb_led_pwm_i2c_pkg::ST_SUB)
    else $error("Stepping not disabled");
  AST_FIRST_BYTE: assert property (@(negedge scl) disable iff (!rst_n)
    !start_f2 && state == rgb_led_pwm_i2c_pkg::ST_ADDR && is_read
      && cnt == rgb_led_pwm_i2c_pkg::ACK_SLOT |=> drive == ~first_byte[7] ##1 drive == ~first_byte[6])
    else $error("First read byte wrong");
  AST_ADDR_NACK: assert property (@(negedge scl) disable iff (!rst_n)
    !start_f2 && state == rgb_led_pwm_i2c_pkg::ST_ADDR && cnt == rgb_led_pwm_i2c_pkg::BIT_LAST
      && rx_shift[7:1] != rgb_led_pwm_i2c_pkg::TARGET_ADDR |=> !drive [*2])
    else $error("Foreign address acknowledged");
  COV_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_event);
  COV_READ2: cover property (@(negedge scl) disable iff (!rst_n) second && cnt == 4'h1);
  COV_ALL_ON: cover property (@(posedge sys_clk) disable iff (!rst_n) led == 3'h7);

endmodule : rgb_led_pwm_i2c_regs

//--- i2c_master_model.sv
// Behavioural I2C bus master driving the LED target link
`timescale 1ns/10ps
module i2c_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Quarter bit time; slow so the target's START detection keeps up
  localparam int Q = 2500;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    sda_low = 1'b1;
    #(2*Q);
    scl = 1'b0;
    #Q;
  endtask : start

  // master ends the read with STOP
  task automatic stop();
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #(2*Q);
    sda_low = 1'b0;
    #(2*Q);
  endtask : stop

  task automatic pulse(output logic seen);
    #Q;
    scl = 1'b1;
    #Q;
    seen = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : pulse

  // address byte sent like any other, msb first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(ack);
    end
    sda_low = 1'b0;
    pulse(ack);
    ack = ~ack;
  endtask : send_byte

  // master acks the first byte, nacks the last
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_low = ~last;
    pulse(s);
    sda_low = 1'b0;
  endtask : recv_byte
endmodule : i2c_master_model

//--- testbench.sv
// Self-checking bench for the LED PWM target register logic
`timescale 1ns/10ps
`define CHECK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  localparam int PERIOD = 15 * rgb_led_pwm_i2c_pkg::PRESCALE_CYCLES;
  logic sys_clk;
  logic rst_n;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic led_out_0;
  logic led_out_1;
  logic led_out_2;
  logic power_save;
  logic [7:0] b1;
  logic [7:0] b2;
  int fails;
  int n_compared;
  int acks;
  int c0;
  int c1;
  int c2;
  // Open-drain wire with pull-up
  wire sda = ~(sda_oe | sda_low);

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  i2c_master_model m (.scl(scl), .sda_low(sda_low), .sda(sda));

  rgb_led_pwm_i2c_regs dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .led_out_0(led_out_0), .led_out_1(led_out_1),
    .led_out_2(led_out_2), .power_save(power_save));

  // ************************************************
  // Transfer tasks
  // ************************************************
  task automatic i2c_write(input logic [7:0] adr, input logic [7:0] q[$], output int n);
    logic a;
    n = 0;
    m.start();
    m.send_byte(adr, a);
    n += int'(a);
    foreach (q[i]) begin
      m.send_byte(q[i], a);
      n += int'(a);
    end
    m.stop();
  endtask : i2c_write

  task automatic i2c_read(output logic [7:0] r1, output logic [7:0] r2);
    logic a;
    m.start();
    m.send_byte({rgb_led_pwm_i2c_pkg::TARGET_ADDR, 1'b1}, a);
    `CHECK("read address ack", 1'b1, a)
    m.recv_byte(1'b0, r1);
    m.recv_byte(1'b1, r2);
    m.stop();
  endtask : i2c_read

  // Over a full PWM period, as in the duty test, the count does not depend on phase
  task automatic led_count(input int cyc);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      c0 += int'(led_out_0);
      c1 += int'(led_out_1);
      c2 += int'(led_out_2);
    end
  endtask : led_count

  task automatic final_report();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // ************************************************
  // Tests
  // ************************************************
  initial begin
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHECK("power_save at reset", 1'b1, power_save)
    `CHECK("sda_o level", 1'b0, sda_o)
    `CHECK("sda_oe idle", 1'b0, sda_oe)
    i2c_read(b1, b2);
    `CHECK("reset byte1", 8'h00, b1 & 8'h3F)
    `CHECK("reset byte2", 8'h00, b2)
    $display("Test reset done");
    i2c_write(8'hAA, '{8'h01, 8'hF5, 8'h3A, 8'h07, 8'h03}, acks);
    `CHECK("stepping write acks", 6, acks)
    i2c_read(b1, b2);
    `CHECK("stepped byte1", 8'h37, b1 & 8'h3F)
    `CHECK("stepped byte2", 8'hA5, b2)
    `CHECK("power_save running", 1'b0, power_save)
    $display("Test auto increment done");
    i2c_write(8'hAA, '{8'h83, 8'h0F, 8'h81, 8'h00}, acks);
    `CHECK("paired write acks", 5, acks)
    i2c_read(b1, b2);
    `CHECK("paired byte1", 8'h3F, b1 & 8'h3F)
    `CHECK("paired byte2", 8'hA0, b2)
    $display("Test no increment done");
    i2c_write(8'hA8, '{8'h84, 8'h00}, acks);
    `CHECK("foreign address acks", 0, acks)
    led_count(PERIOD);
    `CHECK("duty 0 on count", 0, c0)
    `CHECK("duty 10 on count", 10 * rgb_led_pwm_i2c_pkg::PRESCALE_CYCLES, c1)
    `CHECK("duty 15 on count", PERIOD, c2)
    $display("Test duty done");
    i2c_write(8'hAA, '{8'h84, 8'h01}, acks);
    led_count(600);
    `CHECK("disabled leds", 0, c0 + c1 + c2)
    `CHECK("disabled power_save", 1'b0, power_save)
    i2c_write(8'hAA, '{8'h84, 8'h02}, acks);
    led_count(600);
    `CHECK("power down leds", 0, c0 + c1 + c2)
    `CHECK("power down flag", 1'b1, power_save)
    $display("Test control done");
    final_report();
  end

  initial begin
    #3_800_000;
    fails++;
    final_report();
  end
endmodule : testbench
